// ### ifsb_params.svh
// ifsb_params.svh: register offsets, implemented-bit masks, reset values and response codes
// assumes: included by bare name from every design file of the flag status bank except the package
`ifndef IFSB_PARAMS_SVH
`define IFSB_PARAMS_SVH

// ==========================================================================
// register byte offsets on the axi4-lite slave
`define IFSB_OFF_FLAGS0 8'h00
`define IFSB_OFF_FLAGS1 8'h04
`define IFSB_OFF_FLAGS2 8'h08
`define IFSB_OFF_FLAGS3 8'h0c
`define IFSB_OFF_ENABLE0 8'h10
`define IFSB_OFF_ENABLE1 8'h14
`define IFSB_OFF_ENABLE2 8'h18
`define IFSB_OFF_ENABLE3 8'h1c
`define IFSB_OFF_EVT_STATUS 8'h20
`define IFSB_OFF_EVT_MASK 8'h24

// ==========================================================================
// implemented bits per flag word
// word 0: 15 nvm_flag, 13 conversion_done_flag, 12 uart_a_tx_flag, 11 uart_a_rx_flag,
//   10 spi_a_event_flag, 9 spi_a_fault_flag, 8 timer_c_flag, 7 timer_b_flag,
//   6 compare_b_flag, 5 capture_b_flag, 3 timer_a_flag, 2 compare_a_flag,
//   1 capture_a_flag, 0 ext_irq_zero_flag
// word 1: 15 uart_b_tx_flag, 14 uart_b_rx_flag, 13 ext_irq_two_flag, 12 timer_e_flag,
//   11 timer_d_flag, 9 compare_c_flag, 4 ext_irq_one_flag, 3 pin_change_flag,
//   2 comparator_flag, 1 i2c_a_master_flag, 0 i2c_a_slave_flag
// word 2: 5 capture_c_flag, 1 spi_b_event_flag, 0 spi_b_fault_flag
// word 3: 14 calendar_clock_flag, 2 i2c_b_master_flag, 1 i2c_b_slave_flag
`define IFSB_IMPL0 16'hbfef
`define IFSB_IMPL1 16'hfa1f
`define IFSB_IMPL2 16'h0023
`define IFSB_IMPL3 16'h4006

// ==========================================================================
// reset values
`define IFSB_FLAG_RESET 16'h0000
`define IFSB_ENABLE_RESET 16'h0000
`define IFSB_EVT_RESET 4'h0

// ==========================================================================
// axi response codes
`define IFSB_RESP_OKAY 2'b00
`define IFSB_RESP_SLVERR 2'b10

`endif

// ### ifsb_pkg.sv
// ifsb_pkg.sv: types shared by the flag status bank files
// assumes: constants live in ifsb_params.svh, this package holds only types
package ifsb_pkg;

  // ==========================================================================
  // one flag, enable or data word
  typedef logic [15:0] ifsb_word_t;

  // write channel sequencing, one-hot
  typedef enum logic [2:0] {
    IFSB_WS_IDLE = 3'b001,
    IFSB_WS_EXEC = 3'b010,
    IFSB_WS_RESP = 3'b100
  } ifsb_wstate_t;

  // read channel sequencing, one-hot
  typedef enum logic [1:0] {
    IFSB_RS_IDLE = 2'b01,
    IFSB_RS_RESP = 2'b10
  } ifsb_rstate_t;

  // decoded register select: bits 3:2 group, bits 1:0 word index
  typedef enum logic [3:0] {
    IFSB_SEL_FLAGS0 = 4'h0,
    IFSB_SEL_FLAGS1 = 4'h1,
    IFSB_SEL_FLAGS2 = 4'h2,
    IFSB_SEL_FLAGS3 = 4'h3,
    IFSB_SEL_ENABLE0 = 4'h4,
    IFSB_SEL_ENABLE1 = 4'h5,
    IFSB_SEL_ENABLE2 = 4'h6,
    IFSB_SEL_ENABLE3 = 4'h7,
    IFSB_SEL_EVT_STATUS = 4'h8,
    IFSB_SEL_EVT_MASK = 4'h9,
    IFSB_SEL_NONE = 4'hf
  } ifsb_sel_t;

endpackage : ifsb_pkg

// ### ifsb_flag_reg.sv
// ifsb_flag_reg.sv: one 16-bit interrupt flag word, set by hardware, read/write by software
// assumes: single clock aclk, synchronous active-low reset, write strobe already decoded
`include "ifsb_params.svh"

module ifsb_flag_reg #(
  parameter logic [15:0] IMPL = 16'hffff
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [15:0] hw_set,
  input wire logic wr_en,
  input wire logic [15:0] wr_lane,
  input wire logic [15:0] wr_data,
  output logic [15:0] flags
);

  // ==========================================================================
  // next value
  logic [15:0] flags_reg;
  logic [15:0] flags_next;
  logic [15:0] lane_mask;
  logic [15:0] sw_value;

  // software writes only the strobed lanes, ones set and zeros clear
  assign lane_mask = wr_lane & {16{wr_en}};
  assign sw_value = (flags_reg & ~lane_mask) | (wr_data & lane_mask);
  assign flags_next = (sw_value | hw_set) & IMPL;

  // ==========================================================================
  // storage
  // cleared at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= `IFSB_FLAG_RESET;
    end else if (ce) begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule : ifsb_flag_reg

// ### ifsb_top.sv
// ifsb_top.sv: interrupt flag status bank with enables, event summary and axi4-lite slave
// assumes: one clock aclk at 20 MHz, synchronous active-low reset, peripherals give
// request vectors synchronous to aclk, ce held high while the bus is in use
`include "ifsb_params.svh"

// How it works
// - each implemented flag is software read/write and set by its hardware request
// - unimplemented flag positions ignore writes and read back zero
// - flag word 0 upper byte: nvm, -, conversion, uart a tx/rx, spi a, timer c
// - flag word 0 lower byte: timer b, compare b, capture b, -, timer a, compare, capture, ext0
// - word 1 upper: uart b tx/rx, ext2, timer e, timer d, compare c at 9
// - word 1 lower: ext1, pin change, comparator, i2c a master, i2c a slave
// - word 2 holds capture c at 5, spi b event at 1, spi b fault at 0
// - word 3 holds calendar clock at 14, i2c b master at 2, slave at 1
// - every flag and unused bit clears to zero at reset
// - a flag reaches the processor only while its same-position enable bit is one
module ifsb_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] src_req_0,
  input wire logic [15:0] src_req_1,
  input wire logic [15:0] src_req_2,
  input wire logic [15:0] src_req_3,
  output logic cpu_irq_req,
  output logic evt_irq
);

  // ==========================================================================
  // shared decoders
  // address to register select, unmapped or unaligned gives none
  function automatic ifsb_pkg::ifsb_sel_t ifsb_decode(input logic [7:0] addr);
    case (addr)
      `IFSB_OFF_FLAGS0: ifsb_decode = ifsb_pkg::IFSB_SEL_FLAGS0;
      `IFSB_OFF_FLAGS1: ifsb_decode = ifsb_pkg::IFSB_SEL_FLAGS1;
      `IFSB_OFF_FLAGS2: ifsb_decode = ifsb_pkg::IFSB_SEL_FLAGS2;
      `IFSB_OFF_FLAGS3: ifsb_decode = ifsb_pkg::IFSB_SEL_FLAGS3;
      `IFSB_OFF_ENABLE0: ifsb_decode = ifsb_pkg::IFSB_SEL_ENABLE0;
      `IFSB_OFF_ENABLE1: ifsb_decode = ifsb_pkg::IFSB_SEL_ENABLE1;
      `IFSB_OFF_ENABLE2: ifsb_decode = ifsb_pkg::IFSB_SEL_ENABLE2;
      `IFSB_OFF_ENABLE3: ifsb_decode = ifsb_pkg::IFSB_SEL_ENABLE3;
      `IFSB_OFF_EVT_STATUS: ifsb_decode = ifsb_pkg::IFSB_SEL_EVT_STATUS;
      `IFSB_OFF_EVT_MASK: ifsb_decode = ifsb_pkg::IFSB_SEL_EVT_MASK;
      default: ifsb_decode = ifsb_pkg::IFSB_SEL_NONE;
    endcase
  endfunction : ifsb_decode

  // implemented-bit mask of each flag word, shared by flags and enables
  function automatic logic [15:0] ifsb_impl(input logic [1:0] idx);
    case (idx)
      2'h0: ifsb_impl = `IFSB_IMPL0;
      2'h1: ifsb_impl = `IFSB_IMPL1;
      2'h2: ifsb_impl = `IFSB_IMPL2;
      default: ifsb_impl = `IFSB_IMPL3;
    endcase
  endfunction : ifsb_impl

  // ==========================================================================
  // declarations
  ifsb_pkg::ifsb_wstate_t wstate_reg;
  ifsb_pkg::ifsb_wstate_t wstate_next;
  ifsb_pkg::ifsb_rstate_t rstate_reg;
  ifsb_pkg::ifsb_rstate_t rstate_next;
  ifsb_pkg::ifsb_sel_t wr_sel;
  ifsb_pkg::ifsb_sel_t rd_sel;
  ifsb_pkg::ifsb_word_t src_req [4];
  ifsb_pkg::ifsb_word_t req_hit [4];
  ifsb_pkg::ifsb_word_t flag_q [4];
  ifsb_pkg::ifsb_word_t enable_reg [4];
  ifsb_pkg::ifsb_word_t wdata_reg;
  ifsb_pkg::ifsb_word_t wr_lane;
  ifsb_pkg::ifsb_word_t rd_word;
  logic [7:0] awaddr_reg;
  logic [1:0] wstrb_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic b_done;
  logic r_done;
  logic aw_got_next;
  logic w_got_next;
  logic wr_fire;
  logic [3:0] wr_flag_en;
  logic [3:0] wr_enable_en;
  logic [3:0] fwd_word;
  logic fwd_any;
  logic cpu_req_reg;
  logic [3:0] evt_hit;
  logic [3:0] evt_status_reg;
  logic [3:0] evt_status_next;
  logic [3:0] evt_mask_reg;
  logic [3:0] evt_mask_next;
  logic stat_rd;
  logic evt_irq_reg;

  // ==========================================================================
  // request inputs gathered by word
  assign src_req[0] = src_req_0;
  assign src_req[1] = src_req_1;
  assign src_req[2] = src_req_2;
  assign src_req[3] = src_req_3;

  // ==========================================================================
  // write channel: address and data taken in either order, then one exec cycle
  assign aw_take = s_axi_awvalid & awready_reg;
  assign w_take = s_axi_wvalid & wready_reg;
  assign b_done = bvalid_reg & s_axi_bready;
  assign aw_got_next = b_done ? 1'b0 : (aw_got_reg | aw_take);
  assign w_got_next = b_done ? 1'b0 : (w_got_reg | w_take);
  assign wr_fire = (wstate_reg == ifsb_pkg::IFSB_WS_EXEC);
  assign wr_sel = ifsb_decode(awaddr_reg);
  assign wr_lane = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  // write sequencing
  always_comb begin
    unique case (wstate_reg)
      ifsb_pkg::IFSB_WS_IDLE: begin
        wstate_next = (aw_got_next & w_got_next) ? ifsb_pkg::IFSB_WS_EXEC : ifsb_pkg::IFSB_WS_IDLE;
      end
      ifsb_pkg::IFSB_WS_EXEC: begin
        wstate_next = ifsb_pkg::IFSB_WS_RESP;
      end
      ifsb_pkg::IFSB_WS_RESP: begin
        wstate_next = b_done ? ifsb_pkg::IFSB_WS_IDLE : ifsb_pkg::IFSB_WS_RESP;
      end
      default: begin
        wstate_next = ifsb_pkg::IFSB_WS_IDLE;
      end
    endcase
  end

  // write handshake flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_reg <= ifsb_pkg::IFSB_WS_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
    end else if (ce) begin
      wstate_reg <= wstate_next;
      aw_got_reg <= aw_got_next;
      w_got_reg <= w_got_next;
      awready_reg <= ~aw_got_next;
      wready_reg <= ~w_got_next;
    end
  end

  // write payload capture, only the low half-word and its two lanes matter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= 8'h00;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
    end else if (ce) begin
      if (aw_take) awaddr_reg <= s_axi_awaddr;
      if (w_take) wdata_reg <= s_axi_wdata[15:0];
      if (w_take) wstrb_reg <= s_axi_wstrb[1:0];
    end
  end

  // write response, error for an unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `IFSB_RESP_OKAY;
    end else if (ce) begin
      bvalid_reg <= wr_fire | (bvalid_reg & ~s_axi_bready);
      if (wr_fire) begin
        bresp_reg <= (wr_sel == ifsb_pkg::IFSB_SEL_NONE) ? `IFSB_RESP_SLVERR : `IFSB_RESP_OKAY;
      end
    end
  end

  // ==========================================================================
  // assertion clock and reset, declared ahead of every assertion that uses them
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // flag and enable words
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_word
      localparam logic [1:0] IDX = 2'(g);
      localparam logic [15:0] IMPL = ifsb_impl(IDX);

      // write strobes by group and index
      assign wr_flag_en[g] = wr_fire && (wr_sel[3:2] == 2'b00) && (wr_sel[1:0] == IDX);
      assign wr_enable_en[g] = wr_fire && (wr_sel[3:2] == 2'b01) && (wr_sel[1:0] == IDX);
      assign req_hit[g] = src_req[g] & IMPL;
      assign evt_hit[g] = |req_hit[g];
      // forwarded only where flag and enable meet
      assign fwd_word[g] = |(flag_q[g] & enable_reg[g]);

      // flag word with hardware set and software write
      ifsb_flag_reg #(
        .IMPL(IMPL)
      ) u_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .hw_set(req_hit[g]),
        .wr_en(wr_flag_en[g]),
        .wr_lane(wr_lane),
        .wr_data(wdata_reg),
        .flags(flag_q[g])
      );

      // enable word at the same bit positions
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          enable_reg[g] <= `IFSB_ENABLE_RESET;
        end else if (ce && wr_enable_en[g]) begin
          enable_reg[g] <= ((enable_reg[g] & ~wr_lane) | (wdata_reg & wr_lane)) & IMPL;
        end
      end

      // hardware request sets its flag one edge later
      a_flag_hw_set: assert property (ce && (req_hit[g] != 16'h0000) |=>
        ((flag_q[g] & $past(req_hit[g])) == $past(req_hit[g])))
        else $error("hardware request did not set its flag");
      a_unimpl_zero: assert property ((flag_q[g] & ~IMPL) == 16'h0000
        && (enable_reg[g] & ~IMPL) == 16'h0000)
        else $error("unimplemented bit reads nonzero");
      a_flag_sticky: assert property (ce && !wr_flag_en[g] |=>
        ((flag_q[g] & $past(flag_q[g])) == $past(flag_q[g])))
        else $error("flag dropped without a software write");
      a_set_wins: assert property (ce && wr_flag_en[g] && (req_hit[g] != 16'h0000) |=>
        ((flag_q[g] & $past(req_hit[g])) == $past(req_hit[g])))
        else $error("same-cycle clear beat a hardware set");
    end
  endgenerate

  // ==========================================================================
  // processor request: any enabled flag
  assign fwd_any = |fwd_word;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_req_reg <= 1'b0;
    end else if (ce) begin
      cpu_req_reg <= fwd_any;
    end
  end

  // ==========================================================================
  // event summary: one sticky bit per flag word, cleared by reading it
  assign stat_rd = ar_take && (rd_sel == ifsb_pkg::IFSB_SEL_EVT_STATUS);
  assign evt_status_next = (evt_status_reg & {4{~stat_rd}}) | evt_hit;
  assign evt_mask_next = (wr_fire && (wr_sel == ifsb_pkg::IFSB_SEL_EVT_MASK) && wstrb_reg[0])
    ? wdata_reg[3:0] : evt_mask_reg;

  // status, mask and the interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_status_reg <= `IFSB_EVT_RESET;
      evt_mask_reg <= `IFSB_EVT_RESET;
      evt_irq_reg <= 1'b0;
    end else if (ce) begin
      evt_status_reg <= evt_status_next;
      evt_mask_reg <= evt_mask_next;
      evt_irq_reg <= |(evt_status_next & evt_mask_next);
    end
  end

  // ==========================================================================
  // read channel: data registered at the address handshake
  assign ar_take = s_axi_arvalid & arready_reg;
  assign r_done = rvalid_reg & s_axi_rready;
  assign rd_sel = ifsb_decode(s_axi_araddr);
  // unused and unmapped bits read zero
  assign rd_word = (rd_sel[3:2] == 2'b00) ? flag_q[rd_sel[1:0]]
    : (rd_sel[3:2] == 2'b01) ? enable_reg[rd_sel[1:0]]
    : (rd_sel == ifsb_pkg::IFSB_SEL_EVT_STATUS) ? {12'h000, evt_status_reg}
    : (rd_sel == ifsb_pkg::IFSB_SEL_EVT_MASK) ? {12'h000, evt_mask_reg}
    : 16'h0000;
  assign rstate_next = (rstate_reg == ifsb_pkg::IFSB_RS_IDLE)
    ? (ar_take ? ifsb_pkg::IFSB_RS_RESP : ifsb_pkg::IFSB_RS_IDLE)
    : (r_done ? ifsb_pkg::IFSB_RS_IDLE : ifsb_pkg::IFSB_RS_RESP);

  // read handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rstate_reg <= ifsb_pkg::IFSB_RS_IDLE;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end else if (ce) begin
      rstate_reg <= rstate_next;
      arready_reg <= (rstate_next == ifsb_pkg::IFSB_RS_IDLE);
      rvalid_reg <= ar_take | (rvalid_reg & ~s_axi_rready);
    end
  end

  // read data and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_reg <= 32'h00000000;
      rresp_reg <= `IFSB_RESP_OKAY;
    end else if (ce && ar_take) begin
      rdata_reg <= {16'h0000, rd_word};
      rresp_reg <= (rd_sel == ifsb_pkg::IFSB_SEL_NONE) ? `IFSB_RESP_SLVERR : `IFSB_RESP_OKAY;
    end
  end

  // ==========================================================================
  // outputs
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign cpu_irq_req = cpu_req_reg;
  assign evt_irq = evt_irq_reg;

  // ==========================================================================
  // checks
  sequence s_both_taken;
    ce && aw_take && w_take;
  endsequence

  sequence s_exec_then_ce;
    s_both_taken ##1 ce && wr_fire ##1 ce;
  endsequence

  a_map_word0_hi: assert property (ce && src_req_0[13] |=> flag_q[0][13])
    else $error("conversion flag not at bit 13");
  a_map_word0_lo: assert property (ce && src_req_0[4] |=> !flag_q[0][4])
    else $error("word 0 bit 4 must stay zero");
  a_map_word1_hi: assert property (ce && src_req_1[9] |=> flag_q[1][9])
    else $error("compare c flag not at bit 9");
  a_map_word1_lo: assert property (ce && src_req_1[1] |=> flag_q[1][1])
    else $error("i2c a master flag not at bit 1");
  a_map_word2: assert property (ce && src_req_2[5] |=> flag_q[2][5] && flag_q[2][15:6] == 10'h000)
    else $error("capture c flag layout wrong");
  a_map_word3: assert property (ce && src_req_3[14] |=> flag_q[3][14] && !flag_q[3][15])
    else $error("calendar flag layout wrong");
  a_reset_zero: assert property (disable iff (1'b0) !aresetn |=>
    flag_q[0] == 16'h0000 && flag_q[1] == 16'h0000 && flag_q[2] == 16'h0000
    && flag_q[3] == 16'h0000)
    else $error("flags not cleared by reset");
  a_fwd_enabled: assert property (ce && fwd_any ##1 ce |-> cpu_irq_req ##1 (cpu_irq_req || !$past(fwd_any)))
    else $error("enabled flag not forwarded");
  a_fwd_blocked: assert property (ce && (fwd_word == 4'h0) |=> !cpu_irq_req)
    else $error("request forwarded without an enabled flag");
  a_write_answer: assert property (s_exec_then_ce |-> s_axi_bvalid)
    else $error("write response not two edges after handshake");
  a_read_clears: assert property (ce && stat_rd && evt_hit == 4'h0 |=> evt_status_reg == 4'h0)
    else $error("event status not cleared by its read");

endmodule : ifsb_top

// ### ifsb_periph_model.sv
// ifsb_periph_model.sv: stand-in for the peripherals that raise interrupt requests
// assumes: requests are synchronous to aclk and one clock wide, as the flag bank samples them
// ==========================================================================
// peripheral request model
module ifsb_periph_model (
  input wire logic aclk,
  input wire logic fire,
  input wire logic [1:0] word,
  input wire logic [15:0] bits,
  output logic [15:0] req_0 = 16'h0000,
  output logic [15:0] req_1 = 16'h0000,
  output logic [15:0] req_2 = 16'h0000,
  output logic [15:0] req_3 = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // one-cycle pulse on the chosen word, every other word stays idle low
  always_ff @(posedge aclk) begin
    req_0 <= (fire && word == 2'd0) ? bits : 16'h0000;
    req_1 <= (fire && word == 2'd1) ? bits : 16'h0000;
    req_2 <= (fire && word == 2'd2) ? bits : 16'h0000;
    req_3 <= (fire && word == 2'd3) ? bits : 16'h0000;
  end
endmodule : ifsb_periph_model

// ### interrupt_flag_status_bank_bench.sv
// interrupt_flag_status_bank_bench.sv: self-checking bench for the flag status bank
// assumes: ifsb_top with ce held high, peripherals from ifsb_periph_model
`include "ifsb_params.svh"
// ==========================================================================
// bench top
module interrupt_flag_status_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rnd;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, word = 2'd0;
  logic awready, wready, bvalid, arready, rvalid, cpu_irq_req, evt_irq, fire = 1'b0;
  logic [15:0] bits = 16'h0000, req_0, req_1, req_2, req_3;
  logic [15:0] impl [4];
  logic [33:0] rq [$];
  logic [1:0] bq [$];
  int bad_count = 0, tests_run = 0, seed = 9, i;
  // 20 MHz clock
  always #25 aclk = ~aclk;
  ifsb_top ifsb_top_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .src_req_0(req_0), .src_req_1(req_1), .src_req_2(req_2), .src_req_3(req_3),
    .cpu_irq_req(cpu_irq_req), .evt_irq(evt_irq));
  ifsb_periph_model ifsb_periph_model_inst (.aclk(aclk), .fire(fire), .word(word),
    .bits(bits), .req_0(req_0), .req_1(req_1), .req_2(req_2), .req_3(req_3));
  // ==========================================================================
  // compare, report and close
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("mismatches %0d, comparisons %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // ==========================================================================
  // axi4-lite master, expected answers go to the queues
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // wait for the answer, only the watchdog ends a hang
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    rq.push_back(exp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
  // one-cycle request from the peripheral model
  task automatic pulse(input logic [1:0] w, input logic [15:0] b);
    @(posedge aclk);
    fire <= 1'b1;
    word <= w;
    bits <= b;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse
  // ==========================================================================
  // answer monitor: oldest note against each response
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) check({rresp, rdata}, rq.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1) check({32'h0, bresp}, {32'h0, bq.pop_front()});
  end
  // ==========================================================================
  // main sequence
  initial begin
    impl = '{`IFSB_IMPL0, `IFSB_IMPL1, `IFSB_IMPL2, `IFSB_IMPL3};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 10; i++) rd(8'(4 * i), 34'h0);
    for (i = 0; i < 4; i++) begin
      rnd = $random(seed);
      wr(8'(4 * i), rnd, 4'hf, `IFSB_RESP_OKAY);
      rd(8'(4 * i), {18'h0, rnd[15:0] & impl[i]});
      wr(8'(4 * i), 32'hffffffff, 4'h1, `IFSB_RESP_OKAY);
      rd(8'(4 * i), {18'h0, (rnd[15:0] & impl[i] & 16'hff00) | (impl[i] & 16'h00ff)});
      wr(8'(4 * i), 32'h0, 4'hf, `IFSB_RESP_OKAY);
    end
    // requests on unused positions set nothing
    wr(`IFSB_OFF_EVT_MASK, 32'hf, 4'hf, `IFSB_RESP_OKAY);
    pulse(2'd2, ~impl[2]);
    check({33'h0, evt_irq}, 34'h0);
    rd(`IFSB_OFF_FLAGS2, 34'h0);
    pulse(2'd2, 16'h0020);
    check({33'h0, evt_irq}, 34'h1);
    rd(`IFSB_OFF_EVT_STATUS, 34'h4);
    rd(`IFSB_OFF_EVT_STATUS, 34'h0);
    check({33'h0, evt_irq}, 34'h0);
    for (i = 0; i < 4; i++) begin
      pulse(2'(i), 16'hffff);
      repeat (4) @(posedge aclk);
      rd(8'(4 * i), {18'h0, impl[i]});
    end
    check({33'h0, cpu_irq_req}, 34'h0);
    wr(`IFSB_OFF_ENABLE0, 32'h2000, 4'hf, `IFSB_RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({33'h0, cpu_irq_req}, 34'h1);
    wr(`IFSB_OFF_FLAGS0, {16'h0, impl[0] & 16'hdfff}, 4'hf, `IFSB_RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({33'h0, cpu_irq_req}, 34'h0);
    rd(`IFSB_OFF_FLAGS0, {18'h0, impl[0] & 16'hdfff});
    // unmapped and unaligned places
    wr(8'h28, 32'h1, 4'hf, `IFSB_RESP_SLVERR);
    rd(8'h28, {`IFSB_RESP_SLVERR, 32'h0});
    rd(8'h02, {`IFSB_RESP_SLVERR, 32'h0});
    repeat (2) @(posedge aclk);
    end_of_test();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : interrupt_flag_status_bank_bench
